// ---- pkg/gpt_regs.svh ----
// register offsets, field codes and write masks of one timer channel
// assumes byte addresses on a 32-bit register bus, one word per register
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH

// register byte offsets
`define REG_MODE_OFS 12'h800
`define REG_COUNT_OFS 12'h804
`define REG_PWM_OFS 12'h808
`define REG_STATUS_OFS 12'h80c

// writable bits of the mode and pwm registers, and reset values
`define MODE_WMASK_CH0 32'hff33_9737
`define MODE_WMASK_CHN 32'hff33_1737
`define PWM_WMASK 32'hffff_0100
`define MODE_RESET 32'h0000_0000
`define COUNT_RESET 32'h0000_0000
`define PWM_RESET 32'h0000_0000

// pwm force-update bit position
`define PWM_FORCE_BIT 0

// mode field codes
`define MODE_OFF 3'b000
`define MODE_CAPTURE 3'b001
`define MODE_COMPARE 3'b010
`define MODE_PWM 3'b011

// output event type codes
`define OET_FORCE_LOW 2'b00
`define OET_PULSE_HIGH 2'b01
`define OET_PULSE_LOW 2'b10
`define OET_TOGGLE 2'b11

// input edge type codes
`define IET_ANY 2'b00
`define IET_RISE 2'b01
`define IET_FALL 2'b10
`define IET_PULSE 2'b11

// watchdog restart value
`define WD_KICK 8'ha5

`endif

// ---- pkg/gpt_pkg.sv ----
// types shared by the timer channel files
// assumes gpt_regs.svh for the numeric constants
package gpt_pkg;

    // mode control register layout
    typedef struct packed {
        logic [7:0] output_pulse_width;
        logic [1:0] rsv_23;
        logic [1:0] output_event_type;
        logic [1:0] rsv_19;
        logic [1:0] input_edge_type;
        logic watchdog_enable;
        logic [1:0] rsv_14;
        logic counter_enable;
        logic rsv_11;
        logic stop_or_continue;
        logic open_drain_emulation;
        logic irq_enable;
        logic [1:0] rsv_7;
        logic [1:0] pin_io;
        logic rsv_3;
        logic [2:0] mode;
    } mode_ctl_s;

    // latched address phase of a bus transfer
    typedef struct packed {
        logic hit;
        logic wr;
        logic [1:0] idx;
    } bus_cmd_s;

    // counter run state
    typedef enum logic {
        cnt_running,
        cnt_halted
    } cnt_state_e;

endpackage : gpt_pkg

// ---- rtl/tick_prescaler.sv ----
// clock divider producing one tick per prescale-value clocks
// assumes restart_i and run_i come from the same clock domain
`timescale 1ns/1ps
`default_nettype none

module tick_prescaler (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [15:0] prescale_i,
    // tick
    output logic tick_o
);

    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic last_w;

    assign last_w = (div_r >= prescale_i - 16'h0001);
    // zero prescale never ticks
    assign tick_o = run_i & ~restart_i & (prescale_i != 16'h0000) & last_w;
    assign div_nxt = (restart_i | ~run_i | tick_o) ? 16'h0000 : div_r + 16'h0001;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

endmodule : tick_prescaler

`default_nettype wire

// ---- rtl/timer_channel.sv ----
// one general-purpose timer channel with its ahb-lite register slave
// assumes a single clock, timer input pin from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.svh"

// Operation
// - pulse compare output lasts pulse-width undivided clocks, overlaying next period
// - event type: force low, pulse high, pulse low, or toggle
// - capture on any edge, rising, falling, or second edge of pulse
// - channel 0 watchdog expiry in enabled internal timer mode resets device
// - writing a5 to pulse-width byte restarts enabled watchdog counter
// - counter enable gates internal timer counter; cleared holds it reset
// - capture stop resets counter per event; continue accumulates; pulse always stops
// - compare stop halts after first event until mode 000; continue repeats
// - pwm and watchdog modes ignore stop/continue and run continuously
// - cpu timer stop waits after expiry until mode 000; continue restarts
// - open-drain turns every driven one into high impedance
// - irq enable gates requests; watchdog reset ignores it
// - pin field: 0x input, 10 drive low, 11 drive high
// - mode: off, capture, compare, pwm, pin io with internal timer
// - prescaler gives clocks per count; zero stops counting in every mode
// - count sets period or expiry; capture counts from zero
// - counter setup reads back written value, never live counter
// - pwm on-time zero is always off; above period is always on
// - polarity gives off level; on is opposite; period starts on
// - force-update restarts pwm period at once and self-clears
// - capture latches counter into status and requests interrupt
// - pwm flags each period start; new on-time applies next period
// - status flags sticky, write-one clear, cleared in mode 000
// - input pin registered always and readable in status
module timer_channel
    import gpt_pkg::*;
#(
    parameter bit IS_CHANNEL0 = 1'b1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // timer pins
    input wire logic timer_input_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_n_o,
    // system
    output logic irq_o,
    output logic watchdog_reset_o
);

    function automatic logic [1:0] reg_idx(input logic [11:0] a);
        reg_idx = a[3:2];
    endfunction : reg_idx

    // bus slave
    bus_cmd_s cmd_r;
    bus_cmd_s cmd_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic addr_ok_w;
    logic take_w;
    logic wr_mode_w;
    logic wr_count_w;
    logic wr_pwm_w;
    logic wr_stat_w;

    assign addr_ok_w = (haddr_i[11:4] == `REG_MODE_OFS >> 4) && (haddr_i[1:0] == 2'b00)
        && (hsize_i == 3'b010);
    assign take_w = hsel_i & hready_i & htrans_i[1];
    assign cmd_nxt = take_w ? bus_cmd_s'{hit: addr_ok_w, wr: hwrite_i, idx: reg_idx(haddr_i)}
        : bus_cmd_s'{hit: 1'b0, wr: 1'b0, idx: 2'b00};
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_r;
    assign wr_mode_w = cmd_r.hit & cmd_r.wr & (cmd_r.idx == reg_idx(`REG_MODE_OFS));
    assign wr_count_w = cmd_r.hit & cmd_r.wr & (cmd_r.idx == reg_idx(`REG_COUNT_OFS));
    assign wr_pwm_w = cmd_r.hit & cmd_r.wr & (cmd_r.idx == reg_idx(`REG_PWM_OFS));
    assign wr_stat_w = cmd_r.hit & cmd_r.wr & (cmd_r.idx == reg_idx(`REG_STATUS_OFS));

    // registers
    mode_ctl_s mode_r;
    logic [31:0] count_cfg_r;
    logic [31:0] pwm_cfg_r;
    logic [31:0] mode_wmask_w;
    logic force_w;

    assign mode_wmask_w = IS_CHANNEL0 ? `MODE_WMASK_CH0 : `MODE_WMASK_CHN;
    assign force_w = wr_pwm_w & hwdata_i[`PWM_FORCE_BIT];

    // mode decode
    logic off_w;
    logic cap_w;
    logic cmp_w;
    logic pwm_w;
    logic pio_w;
    logic tmr_w;
    logic wd_w;
    logic run_w;
    logic [15:0] period_w;
    logic [15:0] prescale_w;

    assign off_w = (mode_r.mode == `MODE_OFF);
    assign cap_w = (mode_r.mode == `MODE_CAPTURE);
    assign cmp_w = (mode_r.mode == `MODE_COMPARE);
    assign pwm_w = (mode_r.mode == `MODE_PWM);
    assign pio_w = mode_r.mode[2];
    assign tmr_w = pio_w & mode_r.counter_enable;
    assign wd_w = IS_CHANNEL0 & mode_r.watchdog_enable & tmr_w;
    assign prescale_w = count_cfg_r[31:16];

    // input pin sync and edges
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_d_r;
    logic rise_w;
    logic fall_w;
    logic edge_w;
    logic first_seen_r;
    logic pulse_type_w;
    logic cap_evt_w;

    assign rise_w = pin_s2_r & ~pin_d_r;
    assign fall_w = ~pin_s2_r & pin_d_r;
    assign edge_w = rise_w | fall_w;
    assign pulse_type_w = (mode_r.input_edge_type == `IET_PULSE);

    always_comb begin
        case (mode_r.input_edge_type)
            `IET_ANY: cap_evt_w = cap_w & edge_w;
            `IET_RISE: cap_evt_w = cap_w & rise_w;
            `IET_FALL: cap_evt_w = cap_w & fall_w;
            default: cap_evt_w = cap_w & edge_w & first_seen_r;
        endcase
    end

    // counter
    cnt_state_e state_r;
    cnt_state_e state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [2:0] ovf_r;
    logic [15:0] per_sh_r;
    logic [15:0] wid_sh_r;
    logic tick_w;
    logic end_w;
    logic cap_clr_w;
    logic kick_w;
    logic stop_w;
    logic restart_w;

    assign run_w = (cap_w | cmp_w | pwm_w | tmr_w) & (state_r == cnt_running);
    assign period_w = pwm_w ? per_sh_r : count_cfg_r[15:0];
    assign end_w = ~cap_w & tick_w & ({1'b0, cnt_r} + 17'h00001 >= {1'b0, period_w});
    // pulse capture restarts at its first edge so the capture holds its width
    assign cap_clr_w = (cap_evt_w & (~mode_r.stop_or_continue | pulse_type_w))
        | (cap_w & pulse_type_w & edge_w & ~first_seen_r);
    assign kick_w = wd_w & wr_mode_w & (hwdata_i[31:24] == `WD_KICK);
    // stop halts the counter only for compare and plain cpu timer
    assign stop_w = ~mode_r.stop_or_continue & end_w & (cmp_w | (tmr_w & ~wd_w));
    assign restart_w = ~run_w | kick_w | (pwm_w & force_w) | cap_clr_w;

    tick_prescaler u_prescaler (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .run_i(run_w),
        .restart_i(restart_w),
        .prescale_i(prescale_w),
        .tick_o(tick_w)
    );

    always_comb begin
        if (restart_w) begin
            cnt_nxt = 16'h0000;
        end else if (end_w) begin
            cnt_nxt = 16'h0000;
        end else if (tick_w) begin
            cnt_nxt = cnt_r + 16'h0001;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_comb begin
        case (state_r)
            cnt_running: state_nxt = stop_w ? cnt_halted : cnt_running;
            cnt_halted: state_nxt = off_w ? cnt_running : cnt_halted;
            default: state_nxt = cnt_running;
        endcase
    end

    // status flags: capture, compare, pwm period, expiry
    logic [3:0] flags_r;
    logic [3:0] set_w;
    logic [3:0] clr_w;
    logic [15:0] capture_r;

    assign set_w = {tmr_w & end_w, pwm_w & (end_w | force_w), cmp_w & end_w, cap_evt_w};
    assign clr_w = wr_stat_w ? hwdata_i[3:0] : 4'h0;

    // output generation
    logic [7:0] pw_cnt_r;
    logic out_r;
    logic lvl_w;
    logic drive_w;
    logic pulse_on_w;
    logic pwm_on_w;
    logic pin_r;
    logic oe_n_r;
    logic wd_rst_r;

    assign pulse_on_w = (pw_cnt_r != 8'h00);
    assign pwm_on_w = (cnt_r < wid_sh_r);
    assign drive_w = cmp_w | pwm_w | (pio_w & mode_r.pin_io[1]);

    always_comb begin
        if (cmp_w) begin
            case (mode_r.output_event_type)
                `OET_FORCE_LOW: lvl_w = 1'b0;
                `OET_PULSE_HIGH: lvl_w = pulse_on_w;
                `OET_PULSE_LOW: lvl_w = ~pulse_on_w;
                default: lvl_w = out_r;
            endcase
        end else if (pwm_w) begin
            lvl_w = pwm_on_w ^ pwm_cfg_r[8];
        end else if (pio_w) begin
            lvl_w = mode_r.pin_io[0];
        end else begin
            lvl_w = 1'b0;
        end
    end

    // read mux
    always_comb begin
        case (reg_idx(haddr_i))
            reg_idx(`REG_MODE_OFS): rdata_nxt = mode_r;
            reg_idx(`REG_COUNT_OFS): rdata_nxt = count_cfg_r;
            reg_idx(`REG_PWM_OFS): rdata_nxt = pwm_cfg_r;
            default: rdata_nxt = {capture_r, 1'b0, ovf_r, 3'b000, pin_s2_r, 4'h0, flags_r};
        endcase
        if (!(take_w & addr_ok_w & ~hwrite_i)) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_r <= '{hit: 1'b0, wr: 1'b0, idx: 2'b00};
            rdata_r <= 32'h0000_0000;
            mode_r <= `MODE_RESET;
            count_cfg_r <= `COUNT_RESET;
            pwm_cfg_r <= `PWM_RESET;
        end else begin
            cmd_r <= cmd_nxt;
            rdata_r <= rdata_nxt;
            if (wr_mode_w) begin
                mode_r <= hwdata_i & mode_wmask_w;
            end
            if (wr_count_w) begin
                count_cfg_r <= hwdata_i;
            end
            if (wr_pwm_w) begin
                pwm_cfg_r <= hwdata_i & `PWM_WMASK;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // idle level of the pulled-up pin, no false edge after reset
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_d_r <= 1'b1;
            first_seen_r <= 1'b0;
        end else begin
            pin_s1_r <= timer_input_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
            if (!(cap_w & pulse_type_w)) begin
                first_seen_r <= 1'b0;
            end else if (edge_w) begin
                first_seen_r <= ~first_seen_r;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= cnt_running;
            cnt_r <= 16'h0000;
            ovf_r <= 3'b000;
            per_sh_r <= 16'h0000;
            wid_sh_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (off_w | (wr_stat_w & (hwdata_i[3:0] != 4'h0))) begin
                ovf_r <= 3'b000;
            end else if (cap_w & tick_w & ~cap_clr_w & (cnt_r == 16'hffff)) begin
                ovf_r <= ovf_r + 3'b001;
            end
            if (~pwm_w | end_w | force_w) begin
                per_sh_r <= count_cfg_r[15:0];
                wid_sh_r <= force_w ? hwdata_i[31:16] : pwm_cfg_r[31:16];
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_r <= 4'h0;
            capture_r <= 16'h0000;
        end else begin
            if (off_w) begin
                flags_r <= 4'h0;
            end else begin
                flags_r <= (flags_r & ~clr_w) | set_w;
            end
            if (cap_evt_w) begin
                capture_r <= cnt_r;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pw_cnt_r <= 8'h00;
            out_r <= 1'b0;
            pin_r <= 1'b0;
            oe_n_r <= 1'b1;
            wd_rst_r <= 1'b0;
        end else begin
            if (!cmp_w) begin
                pw_cnt_r <= 8'h00;
            end else if (end_w & (mode_r.output_event_type[0] ^ mode_r.output_event_type[1])) begin
                pw_cnt_r <= mode_r.output_pulse_width;
            end else if (pulse_on_w) begin
                pw_cnt_r <= pw_cnt_r - 8'h01;
            end
            if (pio_w & mode_r.pin_io[1]) begin
                out_r <= mode_r.pin_io[0];
            end else if (cmp_w & end_w & (mode_r.output_event_type == `OET_TOGGLE)) begin
                out_r <= ~out_r;
            end
            pin_r <= lvl_w;
            oe_n_r <= ~drive_w | (mode_r.open_drain_emulation & lvl_w);
            wd_rst_r <= wd_w & end_w;
        end
    end

    assign timer_output_pin_o = pin_r;
    assign timer_output_pin_oe_n_o = oe_n_r;
    assign irq_o = mode_r.irq_enable & (flags_r != 4'h0);
    assign watchdog_reset_o = wd_rst_r;

endmodule : timer_channel

`default_nettype wire

// ---- sim/pin_partner.sv ----
// model of the far side of the timer pins
// assumes pull-ups on both pin wires
`timescale 1ns/1ps
`default_nettype none

module pin_partner
    import gpt_pkg::*;
(
    // output pin from the channel
    input wire logic out_i,
    input wire logic oe_n_i,
    // input pin source
    input wire logic drv_en_i,
    input wire logic drv_i,
    // resolved wires
    output logic wire_o,
    output logic tin_o
);
    // released output wire floats to its pull-up
    assign wire_o = oe_n_i ? 1'b1 : out_i;
    // undriven input wire floats to its pull-up
    assign tin_o = drv_en_i ? drv_i : 1'b1;
endmodule : pin_partner

`default_nettype wire

// ---- sim/timer_channel_asserts.sv ----
// port-level checker for one timer channel
// assumes channel 0 and a shadow of the mode register built from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.svh"

module timer_channel_asserts
    import gpt_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_oe_n_o,
    input wire logic irq_o,
    input wire logic watchdog_reset_o
);
    logic take_r;
    logic rd_r;
    logic [31:0] mode_r;
    logic [1:0] age_r;
    wire logic ok = age_r == 2'h3;
    wire logic oe_n = timer_output_pin_oe_n_o;
    wire logic pin = timer_output_pin_o;

    // shadow of mode register and cycles since it changed
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            take_r <= 1'b0;
            rd_r <= 1'b0;
            mode_r <= 32'h0;
            age_r <= 2'h0;
        end else begin
            take_r <= hsel_i & hready_i & htrans_i[1] & hwrite_i & haddr_i == `REG_MODE_OFS
                & hsize_i == 3'h2;
            rd_r <= hsel_i & hready_i & htrans_i[1];
            if (take_r) mode_r <= hwdata_i & `MODE_WMASK_CH0;
            age_r <= take_r ? 2'h0 : (ok ? age_r : age_r + 2'h1);
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_bus_always_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not zero-wait okay");
    chk_rdata_idle_zero: assert property (!rd_r |-> hrdata_o == 32'h0)
        else $error("read data outside data phase");
    chk_wd_needs_enable: assert property (
        (!(mode_r[15] & mode_r[12] & mode_r[2]))[*4] |-> !watchdog_reset_o)
        else $error("watchdog reset while not armed");
    chk_irq_gated_off: assert property (!mode_r[8] |-> !irq_o)
        else $error("irq with irq enable clear");
    chk_flags_mode_off: assert property ((mode_r[2:0] == 3'h0)[*2] |-> !irq_o)
        else $error("flag survives mode off");
    chk_off_pin_free: assert property (ok && mode_r[2:0] == 3'h0 |-> oe_n)
        else $error("pin driven in mode off");
    chk_pin_out_level: assert property (ok && mode_r[2] && mode_r[5] |->
        ((mode_r[4] & mode_r[9]) ? oe_n : (!oe_n && pin == mode_r[4])))
        else $error("pin output level wrong");
    chk_pin_input_free: assert property (ok && mode_r[2] && !mode_r[5] |-> oe_n)
        else $error("pin driven in pin input");
    chk_od_no_one: assert property (ok && mode_r[9] |-> oe_n || !pin)
        else $error("open drain drove a one");
    chk_force_low_out: assert property (
        ok && mode_r[2:0] == 3'h2 && mode_r[21:20] == 2'h0 |-> !oe_n && !pin)
        else $error("compare force low not low");

    cov_wd_fire: cover property (watchdog_reset_o);
    cov_irq_seen: cover property (irq_o);
    cov_cmp_toggle: cover property (mode_r[2:0] == 3'h2 && $changed(pin));
endmodule : timer_channel_asserts

bind timer_channel timer_channel_asserts chk_i (.clock_i, .reset_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
    .timer_output_pin_o, .timer_output_pin_oe_n_o, .irq_o, .watchdog_reset_o);

`default_nettype wire

// ---- sim/timer_channel_tb_top.sv ----
// self-checking bench for one timer channel
// assumes an ahb-lite master here and pull-ups on the pins
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.svh"

module timer_channel_tb_top
    import gpt_pkg::*;
;
    localparam logic [11:0] MR = `REG_MODE_OFS;
    localparam logic [11:0] CR = `REG_COUNT_OFS;
    localparam logic [11:0] PR = `REG_PWM_OFS;
    localparam logic [11:0] SR = `REG_STATUS_OFS;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic drv_en = 1'b0;
    logic drv = 1'b0;
    logic [11:0] haddr_i = 12'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, pin_o, oe_n_o, irq_o, wd_o, pin_wire, timer_input_pin;
    int num_errors = 0;
    int n_compared = 0;
    int wd_cnt = 0;

    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) if (wd_o === 1'b1) wd_cnt <= wd_cnt + 1;

    timer_channel uut (.clock_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
        .timer_input_pin_i(timer_input_pin), .timer_output_pin_o(pin_o),
        .timer_output_pin_oe_n_o(oe_n_o), .irq_o, .watchdog_reset_o(wd_o));
    pin_partner far (.out_i(pin_o), .oe_n_i(oe_n_o), .drv_en_i(drv_en), .drv_i(drv),
        .wire_o(pin_wire), .tin_o(timer_input_pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= a;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        q = hrdata_o;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    task automatic win(input int n, output int hi, output int tg);
        logic p;
        hi = 0;
        tg = 0;
        p = pin_wire;
        repeat (n) begin
            @(posedge clock_i);
            hi += pin_wire;
            tg += (pin_wire != p);
            p = pin_wire;
        end
    endtask : win

    task automatic t_regs;
        rd(MR, `MODE_RESET);
        rd(PR, `PWM_RESET);
        wr(CR, 32'h1234_5678);
        rd(CR, 32'h1234_5678);
        wr(PR, 32'hffff_ffff);
        rd(PR, `PWM_WMASK);
        wr(MR, 32'hffff_ffff);
        rd(MR, `MODE_WMASK_CH0);
        wr(MR, 32'h0);
        wr(12'h810, 32'hffff_ffff);
        rd(12'h810, 32'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_pin;
        wr(MR, 32'h24);
        repeat (3) @(posedge clock_i);
        chk({oe_n_o, pin_wire}, 32'h0);
        wr(MR, 32'h34);
        repeat (3) @(posedge clock_i);
        chk({oe_n_o, pin_wire}, 32'h1);
        wr(MR, 32'h234);
        repeat (3) @(posedge clock_i);
        chk({oe_n_o, pin_wire}, 32'h3);
        wr(MR, 32'h4);
        drv_en <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(SR, 32'h0);
        drv <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(SR, 32'h100);
        wr(MR, 32'h0);
        $display("t_pin done");
    endtask : t_pin

    task automatic t_cmp;
        int hi, tg;
        int e[4] = '{0, 18, 30, 24};
        wr(CR, 32'h0001_0008);
        for (int k = 0; k < 4; k++) begin
            wr(MR, 32'h0);
            wr(MR, 32'h0300_0502 | (k << 20));
            repeat (10) @(posedge clock_i);
            win(48, hi, tg);
            chk(hi, e[k]);
        end
        chk(tg, 6);
        wr(MR, 32'h0);
        wr(MR, 32'h0030_0102);
        repeat (12) @(posedge clock_i);
        win(40, hi, tg);
        chk(tg, 0);
        chk(irq_o, 1);
        wr(SR, 32'h2);
        @(posedge clock_i);
        chk(irq_o, 0);
        wr(MR, 32'h0);
        wr(MR, 32'h34);
        wr(MR, 32'h0030_0402);
        repeat (2) @(posedge clock_i);
        chk(pin_wire, 1);
        repeat (8) @(posedge clock_i);
        chk(pin_wire, 0);
        wr(MR, 32'h0);
        $display("t_cmp done");
    endtask : t_cmp

    task automatic t_pwm;
        int hi, tg;
        logic [31:0] v[4] = '{32'h0003_0000, 32'h0003_0100, 32'h0, 32'h0009_0000};
        int e[4] = '{15, 25, 0, 40};
        for (int k = 0; k < 4; k++) begin
            wr(PR, v[k] | 32'h1);
            wr(MR, 32'h3);
            repeat (20) @(posedge clock_i);
            win(40, hi, tg);
            chk(hi, e[k]);
        end
        wr(MR, 32'h0);
        $display("t_pwm done");
    endtask : t_pwm

    task automatic t_cap;
        logic [31:0] q;
        drv <= 1'b0;
        wr(CR, 32'h0001_0000);
        wr(MR, 32'h0003_0101);
        repeat (4) @(posedge clock_i);
        drv <= 1'b1;
        repeat (10) @(posedge clock_i);
        drv <= 1'b0;
        repeat (6) @(posedge clock_i);
        bus(1'b0, SR, 32'h0, q);
        chk(q[0], 1);
        chk(q[31:16] >= 16'h9 && q[31:16] <= 16'hb, 1);
        chk(irq_o, 1);
        wr(MR, 32'h0);
        $display("t_cap done");
    endtask : t_cap

    task automatic t_wd;
        logic [31:0] q;
        wr(CR, 32'h0001_0014);
        wr(MR, 32'h1104);
        repeat (50) @(posedge clock_i);
        bus(1'b0, SR, 32'h0, q);
        chk(q[3:0], 32'h8);
        wr(SR, 32'h8);
        repeat (30) @(posedge clock_i);
        chk(irq_o, 0);
        wr(MR, 32'h0);
        wr(MR, 32'h8004);
        repeat (30) @(posedge clock_i);
        chk(wd_cnt, 0);
        wr(MR, 32'h9004);
        repeat (6) begin
            repeat (6) @(posedge clock_i);
            wr(MR, 32'ha500_9004);
        end
        chk(wd_cnt, 0);
        repeat (30) @(posedge clock_i);
        chk(wd_cnt, 1);
        wr(MR, 32'h0);
        $display("t_wd done");
    endtask : t_wd

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        #160000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        t_regs();
        t_pin();
        t_cmp();
        t_pwm();
        t_cap();
        t_wd();
        finish_test();
    end
endmodule : timer_channel_tb_top

`default_nettype wire
